// ==== rtl/qesc_pkg.sv ====
// shared constants and types for the encoder status and counter block
package qesc_pkg;

  // data widths
  localparam int unsigned REG_W       = 16;          // register word width
  localparam int unsigned POS_W       = 32;          // position counter width
  localparam int unsigned VEL_W       = 16;          // velocity counter width
  localparam int unsigned IDX_W       = 32;          // index counter width
  localparam int unsigned ADDR_W      = 4;           // register address width
  localparam int unsigned MODE_W      = 3;           // position init mode width
  localparam int unsigned NUM_FLAGS   = 7;           // event flags in the status word

  // register offsets, one word each
  localparam logic [3:0] OFS_STATUS   = 4'h0;        // encoder_event_status
  localparam logic [3:0] OFS_POS_HI   = 4'h1;        // position_count_high
  localparam logic [3:0] OFS_POS_LO   = 4'h2;        // position_count_low
  localparam logic [3:0] OFS_POS_HOLD = 4'h3;        // position_hold
  localparam logic [3:0] OFS_VEL      = 4'h4;        // velocity_count
  localparam logic [3:0] OFS_IDX_HI   = 4'h5;        // index_count_high
  localparam logic [3:0] OFS_IDX_LO   = 4'h6;        // index_count_low
  localparam logic [3:0] OFS_IDX_HOLD = 4'h7;        // index_hold

  // event flag indices; flag k sits at status bit 2k+1, its enable at 2k
  localparam int unsigned FLG_INDEX   = 0;           // index_event_flag, bit 1
  localparam int unsigned FLG_HOME    = 1;           // home_event_flag, bit 3
  localparam int unsigned FLG_VEL_OVF = 2;           // velocity_overflow_flag, bit 5
  localparam int unsigned FLG_HOMING  = 3;           // homing_done_flag, bit 7
  localparam int unsigned FLG_POS_OVF = 4;           // position_overflow_flag, bit 9
  localparam int unsigned FLG_LOWER   = 5;           // lower_compare_flag, bit 11
  localparam int unsigned FLG_UPPER   = 6;           // upper_compare_flag, bit 13
  localparam int unsigned STAT_UNUSED_LSB = 14;      // bits 15:14 read zero

  // reset values
  localparam logic [15:0] STATUS_RST  = 16'h0000;
  localparam logic [15:0] WORD_RST    = 16'h0000;

  // position init modes that use the home-then-index sequence
  localparam logic [2:0] MODE_HOME_IDX1 = 3'h3;      // first index after home
  localparam logic [2:0] MODE_HOME_IDX2 = 3'h4;      // second index after home

  // homing sequencer states, gray along idle -> armed -> second
  typedef enum logic [1:0] {
    HOME_IDLE   = 2'h0,
    HOME_ARMED  = 2'h1,
    HOME_SECOND = 2'h3
  } qesc_home_state_type;

endpackage

// ==== rtl/qesc_event_flag.sv ====
// sticky event flag: hardware sets, software clears, set wins
module qesc_event_flag (
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_clk_en,
  // set and clear requests
  input  wire logic i_set,
  input  wire logic i_clr,
  // flag state
  output logic      o_flag
);

  // set wins so an event landing on the clear cycle is kept
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_flag <= 1'b0;
    end else if (i_clk_en) begin
      if (i_set) begin
        o_flag <= 1'b1;
      end else if (i_clr) begin
        o_flag <= 1'b0;
      end
    end
  end

endmodule

// ==== rtl/qesc_step_counter.sv ====
// loadable up/down counter with signed wrap detection
module qesc_step_counter #(
  parameter int unsigned WIDTH = 32
) (
  // clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_clk_en,
  // load path, wins over a step
  input  wire logic             i_load,
  input  wire logic [WIDTH-1:0] i_load_value,
  // count path
  input  wire logic             i_step,
  input  wire logic             i_count_up,
  // state
  output logic      [WIDTH-1:0] o_count,
  output logic                  o_wrap
);

  localparam logic [WIDTH-1:0] MAX_POS = {1'b0, {(WIDTH-1){1'b1}}}; // most positive
  localparam logic [WIDTH-1:0] MAX_NEG = {1'b1, {(WIDTH-1){1'b0}}}; // most negative

  // wrap pulse in the cycle the step crosses the signed limit
  assign o_wrap = i_step && !i_load &&
                  (i_count_up ? (o_count == MAX_POS) : (o_count == MAX_NEG));

  // count update
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_count <= '0;
    end else if (i_clk_en) begin
      if (i_load) begin
        o_count <= i_load_value;
      end else if (i_step) begin
        o_count <= i_count_up ? o_count + 1'b1 : o_count - 1'b1;
      end
    end
  end

endmodule

// ==== rtl/qesc_top.sv ====
// encoder status flags, interrupt enables and counter register set
//
// Operation
// - upper flag set while position at/above upper
// - lower flag set while position at/below lower
// - position overflow sets flag bit 9
// - homing reload sets flag bit 7
// - homing flag only in home-index modes
// - velocity overflow sets flag bit 5
// - home event sets flag bit 3
// - index event sets flag bit 1
// - enable bit below each flag gates interrupt
// - flags set by hardware, cleared by software
// - status bits 15 and 14 read zero
// - position counter as two 16-bit words
// - position hold word for coherent access
// - 16-bit read/write velocity counter
// - index counter as two 16-bit words
// - all counters and holds reset to zero
// - first/second index after home reloads position
// - index hold word for coherent access
module qesc_top (
  // clock, reset, clock enable
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_clk_en,
  // register port
  input  wire logic [3:0]  i_reg_addr,
  input  wire logic [15:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [15:0] o_reg_rdata,
  // decoded encoder events
  input  wire logic        i_pos_step,
  input  wire logic        i_count_up,
  input  wire logic        i_index_event,
  input  wire logic        i_home_event,
  // settings from the neighbouring control registers
  input  wire logic [2:0]  i_position_init_mode,
  input  wire logic [31:0] i_upper_compare_value,
  input  wire logic [31:0] i_lower_compare_value,
  input  wire logic [31:0] i_initialization_value,
  // results
  output logic      [31:0] o_position_count,
  output logic             o_irq_req
);

  // register access decode
  logic wr_status;                                   // status word write
  logic wr_pos_hi;                                   // position high write
  logic wr_pos_lo;                                   // position low write
  logic wr_pos_hold;                                 // position hold write
  logic wr_vel;                                      // velocity write
  logic wr_idx_hi;                                   // index high write
  logic wr_idx_lo;                                   // index low write
  logic wr_idx_hold;                                 // index hold write
  logic rd_pos_lo;                                   // position low read
  logic rd_idx_lo;                                   // index low read

  // counters and holds
  logic [31:0] pos_count;                            // position_count
  logic [15:0] vel_count;                            // velocity_count
  logic [31:0] idx_count;                            // index_count
  logic [15:0] pos_hold_r;                           // position_hold
  logic [15:0] idx_hold_r;                           // index hold word
  logic        pos_wrap;                             // position overflow pulse
  logic        vel_wrap;                             // velocity overflow pulse
  logic        pos_load;                             // any position load
  logic [31:0] pos_load_value;                       // value for that load
  logic        idx_load;                             // any index load
  logic [31:0] idx_load_value;                       // value for that load

  // homing sequencer
  qesc_pkg::qesc_home_state_type home_state_r;       // current state
  qesc_pkg::qesc_home_state_type home_state_nxt;     // next state
  logic        home_mode;                            // home-then-index mode selected
  logic        homing_load;                          // reload of position by homing

  // status flags and enables
  logic [6:0]  flag_set;                             // hardware set per flag
  logic [6:0]  flag_clr;                             // software clear per flag
  logic [6:0]  flags;                                // flag state
  logic [6:0]  enables_r;                            // interrupt enables
  logic [15:0] status_word;                          // assembled status view
  logic [15:0] rdata_r;                              // registered read data

  // strobes are ignored while the clock enable holds the block frozen
  assign wr_status   = i_reg_wr && (i_reg_addr == qesc_pkg::OFS_STATUS);
  assign wr_pos_hi   = i_reg_wr && (i_reg_addr == qesc_pkg::OFS_POS_HI);
  assign wr_pos_lo   = i_reg_wr && (i_reg_addr == qesc_pkg::OFS_POS_LO);
  assign wr_pos_hold = i_reg_wr && (i_reg_addr == qesc_pkg::OFS_POS_HOLD);
  assign wr_vel      = i_reg_wr && (i_reg_addr == qesc_pkg::OFS_VEL);
  assign wr_idx_hi   = i_reg_wr && (i_reg_addr == qesc_pkg::OFS_IDX_HI);
  assign wr_idx_lo   = i_reg_wr && (i_reg_addr == qesc_pkg::OFS_IDX_LO);
  assign wr_idx_hold = i_reg_wr && (i_reg_addr == qesc_pkg::OFS_IDX_HOLD);
  assign rd_pos_lo   = i_reg_rd && (i_reg_addr == qesc_pkg::OFS_POS_LO);
  assign rd_idx_lo   = i_reg_rd && (i_reg_addr == qesc_pkg::OFS_IDX_LO);

  // homing sequencer: home arms, first or second index reloads
  assign home_mode = (i_position_init_mode == qesc_pkg::MODE_HOME_IDX1) ||
                     (i_position_init_mode == qesc_pkg::MODE_HOME_IDX2);

  always_comb begin
    home_state_nxt = home_state_r;
    homing_load    = 1'b0;
    case (home_state_r)
      qesc_pkg::HOME_IDLE: begin
        // wait for a home event
        if (home_mode && i_home_event) begin
          home_state_nxt = qesc_pkg::HOME_ARMED;
        end
      end
      qesc_pkg::HOME_ARMED: begin
        // first index after home
        if (!home_mode) begin
          home_state_nxt = qesc_pkg::HOME_IDLE;
        end else if (i_index_event) begin
          if (i_position_init_mode == qesc_pkg::MODE_HOME_IDX1) begin
            homing_load    = 1'b1;
            home_state_nxt = qesc_pkg::HOME_IDLE;
          end else begin
            home_state_nxt = qesc_pkg::HOME_SECOND;
          end
        end
      end
      qesc_pkg::HOME_SECOND: begin
        // second index after home
        if (!home_mode) begin
          home_state_nxt = qesc_pkg::HOME_IDLE;
        end else if (i_index_event) begin
          homing_load    = 1'b1;
          home_state_nxt = qesc_pkg::HOME_IDLE;
        end
      end
      default: begin
        home_state_nxt = qesc_pkg::HOME_IDLE;
      end
    endcase
  end

  // sequencer state register
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      home_state_r <= qesc_pkg::HOME_IDLE;
    end else if (i_clk_en) begin
      home_state_r <= home_state_nxt;
    end
  end

  // position load: homing reload wins over a software write
  always_comb begin
    pos_load       = homing_load || wr_pos_hi || wr_pos_lo;
    pos_load_value = pos_count;
    if (homing_load) begin
      pos_load_value = i_initialization_value;
    end else if (wr_pos_lo) begin
      pos_load_value = {pos_hold_r, i_reg_wdata};
    end else if (wr_pos_hi) begin
      pos_load_value = {i_reg_wdata, pos_count[15:0]};
    end
  end

  // index load from software only
  always_comb begin
    idx_load       = wr_idx_hi || wr_idx_lo;
    idx_load_value = idx_count;
    if (wr_idx_lo) begin
      idx_load_value = {idx_hold_r, i_reg_wdata};
    end else if (wr_idx_hi) begin
      idx_load_value = {i_reg_wdata, idx_count[15:0]};
    end
  end

  // position counter, steps on each decoded count
  qesc_step_counter #(
    .WIDTH(qesc_pkg::POS_W)
  ) u_pos_cnt (
    .i_core_clk  (i_core_clk),
    .i_sys_rst   (i_sys_rst),
    .i_clk_en    (i_clk_en),
    .i_load      (pos_load),
    .i_load_value(pos_load_value),
    .i_step      (i_pos_step),
    .i_count_up  (i_count_up),
    .o_count     (pos_count),
    .o_wrap      (pos_wrap)
  );

  // velocity counter, same steps, written directly by software
  qesc_step_counter #(
    .WIDTH(qesc_pkg::VEL_W)
  ) u_vel_cnt (
    .i_core_clk  (i_core_clk),
    .i_sys_rst   (i_sys_rst),
    .i_clk_en    (i_clk_en),
    .i_load      (wr_vel),
    .i_load_value(i_reg_wdata),
    .i_step      (i_pos_step),
    .i_count_up  (i_count_up),
    .o_count     (vel_count),
    .o_wrap      (vel_wrap)
  );

  // index counter, one count per index event; wrap is not flagged
  qesc_step_counter #(
    .WIDTH(qesc_pkg::IDX_W)
  ) u_idx_cnt (
    .i_core_clk  (i_core_clk),
    .i_sys_rst   (i_sys_rst),
    .i_clk_en    (i_clk_en),
    .i_load      (idx_load),
    .i_load_value(idx_load_value),
    .i_step      (i_index_event),
    .i_count_up  (i_count_up),
    .o_count     (idx_count),
    .o_wrap      ()
  );

  // position hold: low read latches high word, or direct write
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pos_hold_r <= qesc_pkg::WORD_RST;
    end else if (i_clk_en) begin
      if (rd_pos_lo) begin
        pos_hold_r <= pos_count[31:16];
      end else if (wr_pos_hold) begin
        pos_hold_r <= i_reg_wdata;
      end
    end
  end

  // index hold: same scheme as the position hold
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      idx_hold_r <= qesc_pkg::WORD_RST;
    end else if (i_clk_en) begin
      if (rd_idx_lo) begin
        idx_hold_r <= idx_count[31:16];
      end else if (wr_idx_hold) begin
        idx_hold_r <= i_reg_wdata;
      end
    end
  end

  // hardware set conditions; compare flags re-set every cycle the match holds
  always_comb begin
    flag_set                       = '0;
    flag_set[qesc_pkg::FLG_INDEX]  = i_index_event;
    flag_set[qesc_pkg::FLG_HOME]   = i_home_event;
    flag_set[qesc_pkg::FLG_VEL_OVF]= vel_wrap;
    flag_set[qesc_pkg::FLG_HOMING] = homing_load && home_mode;
    flag_set[qesc_pkg::FLG_POS_OVF]= pos_wrap;
    flag_set[qesc_pkg::FLG_LOWER]  =
      $signed(pos_count) <= $signed(i_lower_compare_value);
    flag_set[qesc_pkg::FLG_UPPER]  =
      $signed(pos_count) >= $signed(i_upper_compare_value);
  end

  // one sticky flag per event; writing zero to its bit clears it
  for (genvar k = 0; k < qesc_pkg::NUM_FLAGS; k++) begin : g_flag
    assign flag_clr[k] = wr_status && !i_reg_wdata[2*k+1];
    qesc_event_flag u_flag (
      .i_core_clk(i_core_clk),
      .i_sys_rst (i_sys_rst),
      .i_clk_en  (i_clk_en),
      .i_set     (flag_set[k]),
      .i_clr     (flag_clr[k]),
      .o_flag    (flags[k])
    );
    assign status_word[2*k+1] = flags[k];
    assign status_word[2*k]   = enables_r[k];
  end

  // unimplemented top bits
  assign status_word[15:qesc_pkg::STAT_UNUSED_LSB] = 2'h0;

  // interrupt enables, plain read/write bits below each flag
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      enables_r <= '0;
    end else if (i_clk_en && wr_status) begin
      for (int k = 0; k < qesc_pkg::NUM_FLAGS; k++) begin
        enables_r[k] <= i_reg_wdata[2*k];
      end
    end
  end

  // read data registered, valid only the cycle after the strobe
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rdata_r <= qesc_pkg::WORD_RST;
    end else if (i_clk_en) begin
      rdata_r <= 16'h0000;
      if (i_reg_rd) begin
        case (i_reg_addr)
          qesc_pkg::OFS_STATUS:   rdata_r <= status_word;
          qesc_pkg::OFS_POS_HI:   rdata_r <= pos_count[31:16];
          qesc_pkg::OFS_POS_LO:   rdata_r <= pos_count[15:0];
          qesc_pkg::OFS_POS_HOLD: rdata_r <= pos_hold_r;
          qesc_pkg::OFS_VEL:      rdata_r <= vel_count;
          qesc_pkg::OFS_IDX_HI:   rdata_r <= idx_count[31:16];
          qesc_pkg::OFS_IDX_LO:   rdata_r <= idx_count[15:0];
          qesc_pkg::OFS_IDX_HOLD: rdata_r <= idx_hold_r;
          default:                rdata_r <= 16'h0000;
        endcase
      end
    end
  end

  assign o_reg_rdata      = rdata_r;
  assign o_position_count = pos_count;
  // level request while any flag and its enable are both set
  assign o_irq_req        = |(flags & enables_r);

  // checks on the logic above
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  upper_cmp_set_a: assert property (
    i_clk_en && ($signed(pos_count) >= $signed(i_upper_compare_value))
      |=> status_word[13])
    else $error("upper compare flag not set");

  lower_cmp_set_a: assert property (
    i_clk_en && ($signed(pos_count) <= $signed(i_lower_compare_value))
      |=> status_word[11])
    else $error("lower compare flag not set");

  pos_ovf_set_a: assert property (
    i_clk_en && i_pos_step && !pos_load && i_count_up && (pos_count == 32'h7FFFFFFF)
      |=> status_word[9] && (pos_count == 32'h80000000))
    else $error("position overflow not flagged");

  homing_load_a: assert property (
    i_clk_en && (home_state_r == qesc_pkg::HOME_SECOND) && home_mode && i_index_event
      |=> (pos_count == $past(i_initialization_value)) && status_word[7])
    else $error("homing reload missing");

  homing_mode_a: assert property (
    $rose(status_word[7]) |-> $past(home_mode))
    else $error("homing flag outside home modes");

  vel_ovf_set_a: assert property (
    i_clk_en && vel_wrap |=> status_word[5])
    else $error("velocity overflow not flagged");

  home_flag_a: assert property (
    i_clk_en && i_home_event |=> status_word[3] ##1 (status_word[3] || $past(wr_status)))
    else $error("home flag not set");

  index_flag_a: assert property (
    i_clk_en && i_index_event |=> status_word[1])
    else $error("index flag not set");

  irq_gate_a: assert property (
    i_clk_en && wr_status && ((i_reg_wdata & 16'h1555) == 16'h0000) |=> !o_irq_req)
    else $error("interrupt with all enables clear");

  unused_bits_a: assert property (
    i_clk_en && i_reg_rd && (i_reg_addr == qesc_pkg::OFS_STATUS)
      |=> o_reg_rdata[15:14] == 2'h0)
    else $error("status top bits not zero");

  lo_read_latch_a: assert property (
    i_clk_en && rd_pos_lo |=> pos_hold_r == $past(pos_count[31:16]))
    else $error("position hold not latched");

  reset_clear_a: assert property (
    @(posedge i_core_clk) disable iff (1'b0)
    $past(i_sys_rst) |-> (pos_count == 32'h0) && (idx_count == 32'h0) &&
      (vel_count == 16'h0) && (pos_hold_r == 16'h0) && (idx_hold_r == 16'h0))
    else $error("counters not cleared by reset");

endmodule

// ==== tb/qesc_encoder_model.sv ====
// behavioural encoder: position steps, index and home pulses
module qesc_encoder_model (
  // clock
  input  wire logic i_core_clk,
  // decoded encoder events
  output logic      o_pos_step,
  output logic      o_count_up,
  output logic      o_index_event,
  output logic      o_home_event
);
  timeunit 1ns;
  timeprecision 1ns;

  // quiet encoder at power-up, counting up
  initial begin
    o_pos_step    = 1'b0;
    o_count_up    = 1'b1;
    o_index_event = 1'b0;
    o_home_event  = 1'b0;
  end

  // n steps back to back, direction held for the burst
  task automatic steps(input int n, input logic up);
    @(posedge i_core_clk);
    o_count_up <= up;
    o_pos_step <= 1'b1;
    repeat (n) @(posedge i_core_clk);
    o_pos_step <= 1'b0;
  endtask

  // one-cycle index pulse
  task automatic index_pulse();
    @(posedge i_core_clk);
    o_index_event <= 1'b1;
    @(posedge i_core_clk);
    o_index_event <= 1'b0;
  endtask

  // one-cycle home pulse
  task automatic home_pulse();
    @(posedge i_core_clk);
    o_home_event <= 1'b1;
    @(posedge i_core_clk);
    o_home_event <= 1'b0;
  endtask
endmodule

// ==== tb/qesc_top_bench.sv ====
// self-checking bench for the encoder status and counter block
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("wrong value at %0t ns: got %h want %h", $time, a, e); end end
module qesc_top_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk;    // 20 MHz core clock
  logic        rst;    // sync reset
  logic        en;     // clock enable
  logic [3:0]  addr;   // register index
  logic [15:0] wdata;  // write data
  logic        wr;     // write strobe
  logic        rd;     // read strobe
  logic [15:0] rdata;  // read data
  logic        step;   // encoder step
  logic        up;     // direction
  logic        idx;    // index pulse
  logic        home;   // home pulse
  logic [2:0]  mode;   // position init mode
  logic [31:0] init;   // initialization value
  logic [31:0] pos;    // position count
  logic        irq;    // interrupt request
  logic [15:0] d;      // last read word
  int          fail_count;
  int          total_checks;
  int          cycles;

  // design; compare window 0x100 / -256 keeps position 0 outside both
  qesc_top u_qesc_top (.i_core_clk(clk), .i_sys_rst(rst), .i_clk_en(en),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .i_pos_step(step), .i_count_up(up), .i_index_event(idx),
    .i_home_event(home), .i_position_init_mode(mode),
    .i_upper_compare_value(32'h0000_0100), .i_lower_compare_value(32'hFFFF_FF00),
    .i_initialization_value(init), .o_position_count(pos), .o_irq_req(irq));

  // far-side encoder
  qesc_encoder_model u_qesc_encoder_model (.i_core_clk(clk), .o_pos_step(step),
    .o_count_up(up), .o_index_event(idx), .o_home_event(home));

  // clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // hang guard, far above the roughly 140 cycles used
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      wrap_up();
    end
  end

  // one-cycle write; #1 lets the write land before callers look
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  // one-cycle read; data only stands in the following cycle
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  // read a register and compare the whole word
  task automatic chk_reg(input logic [3:0] a, input logic [15:0] e);
    rd_reg(a, d);
    `CHK(d, e)
  endtask

  // read status and compare one bit
  task automatic chk_bit(input int b, input logic e);
    rd_reg(qesc_pkg::OFS_STATUS, d);
    `CHK(d[b], e)
  endtask

  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    en = 1'b1;
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    mode = 3'h0;
    init = 32'h1234_5678;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // reset values, unmapped index 8 included
    for (int a = 0; a < 9; a++) chk_reg(a[3:0], 16'h0000);
    // software cannot set flags; top bits stay zero
    wr_reg(qesc_pkg::OFS_STATUS, 16'hFFFF);
    chk_reg(qesc_pkg::OFS_STATUS, 16'h1555);
    `CHK(irq, 1'b0)
    u_qesc_encoder_model.index_pulse();
    chk_reg(qesc_pkg::OFS_STATUS, 16'h1557);
    `CHK(irq, 1'b1)
    wr_reg(qesc_pkg::OFS_STATUS, 16'h1555);
    `CHK(irq, 1'b0)
    u_qesc_encoder_model.home_pulse();
    chk_reg(qesc_pkg::OFS_STATUS, 16'h155D);
    // index counter through its hold word
    chk_reg(qesc_pkg::OFS_IDX_LO, 16'h0001);
    chk_reg(qesc_pkg::OFS_IDX_HOLD, 16'h0000);
    wr_reg(qesc_pkg::OFS_IDX_HOLD, 16'h0001);
    wr_reg(qesc_pkg::OFS_IDX_LO, 16'h0002);
    chk_reg(qesc_pkg::OFS_IDX_HI, 16'h0001);
    // position and velocity counting
    u_qesc_encoder_model.steps(5, 1'b1);
    chk_reg(qesc_pkg::OFS_POS_LO, 16'h0005);
    chk_reg(qesc_pkg::OFS_POS_HOLD, 16'h0000);
    chk_reg(qesc_pkg::OFS_VEL, 16'h0005);
    wr_reg(qesc_pkg::OFS_POS_HI, 16'h00AA);
    `CHK(pos, 32'h00AA_0005)
    // coherent 32-bit write, then wrap both counters
    wr_reg(qesc_pkg::OFS_POS_HOLD, 16'h7FFF);
    wr_reg(qesc_pkg::OFS_POS_LO, 16'hFFFF);
    `CHK(pos, 32'h7FFF_FFFF)
    chk_bit(13, 1'b1);
    chk_bit(11, 1'b0);
    wr_reg(qesc_pkg::OFS_VEL, 16'h7FFF);
    u_qesc_encoder_model.steps(1, 1'b1);
    #1;
    `CHK(pos, 32'h8000_0000)
    chk_bit(9, 1'b1);
    chk_bit(5, 1'b1);
    chk_bit(11, 1'b1);
    chk_reg(qesc_pkg::OFS_VEL, 16'h8000);
    wr_reg(qesc_pkg::OFS_STATUS, 16'h1555);
    chk_bit(13, 1'b0);
    chk_bit(9, 1'b0);
    // homing ignored outside the home-then-index modes
    u_qesc_encoder_model.home_pulse();
    u_qesc_encoder_model.index_pulse();
    chk_bit(7, 1'b0);
    `CHK(pos, 32'h8000_0000)
    // first index after home reloads
    @(posedge clk) mode <= qesc_pkg::MODE_HOME_IDX1;
    u_qesc_encoder_model.home_pulse();
    u_qesc_encoder_model.index_pulse();
    #1;
    `CHK(pos, 32'h1234_5678)
    chk_bit(7, 1'b1);
    // second index after home reloads
    @(posedge clk) mode <= qesc_pkg::MODE_HOME_IDX2;
    init <= 32'h00AB_CDEF;
    wr_reg(qesc_pkg::OFS_STATUS, 16'h1555);
    u_qesc_encoder_model.home_pulse();
    u_qesc_encoder_model.index_pulse();
    chk_bit(7, 1'b0);
    u_qesc_encoder_model.index_pulse();
    #1;
    `CHK(pos, 32'h00AB_CDEF)
    chk_bit(7, 1'b1);
    // low read latches a nonzero high word
    chk_reg(qesc_pkg::OFS_IDX_LO, 16'h0006);
    chk_reg(qesc_pkg::OFS_IDX_HOLD, 16'h0001);
    // clock enable low freezes the counters while steps arrive
    wr_reg(qesc_pkg::OFS_POS_HOLD, 16'h8000);
    wr_reg(qesc_pkg::OFS_POS_LO, 16'h0000);
    @(posedge clk) en <= 1'b0;
    u_qesc_encoder_model.steps(3, 1'b0);
    #1;
    `CHK(pos, 32'h8000_0000)
    // one step down wraps both position and velocity
    @(posedge clk) en <= 1'b1;
    u_qesc_encoder_model.steps(1, 1'b0);
    #1;
    `CHK(pos, 32'h7FFF_FFFF)
    chk_bit(9, 1'b1);
    chk_reg(qesc_pkg::OFS_VEL, 16'h7FFF);
    // every flag now set; clearing all enables blocks the request
    chk_reg(qesc_pkg::OFS_STATUS, 16'h3FFF);
    `CHK(irq, 1'b1)
    wr_reg(qesc_pkg::OFS_STATUS, 16'h2AAA);
    `CHK(irq, 1'b0)
    chk_reg(qesc_pkg::OFS_STATUS, 16'h2AAA);
    wrap_up();
  end
endmodule
